// ===== adc_host_model.sv
// Host-side serial reader that clocks result words out of the sequencer.
// Assumes the bench calls frame() and supplies the sys_clk domain separately.
`timescale 1ns/1ns

// ==========================================================================
// Serial host
module adc_host_model (
	output logic sclk,
	output logic cs_n,
	input wire logic dout
);
	// The clock stands still between frames and the select idles high
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
	end

	// One frame of nbits clocks at 48 ns; a short frame leaves the word unconsumed
	task automatic frame(input int nbits, output logic [23:0] word);
		word = 24'h0;
		#3;
		cs_n = 1'b0;
		#24;
		for (int i = 0; i < nbits; i++) begin
			sclk = 1'b1;
			#24;
			sclk = 1'b0;
			word = {word[22:0], dout};
			#24;
		end
		cs_n = 1'b1;
		#24;
	endtask
endmodule

// ===== adc_operating_mode_sequencer.sv
// Operating-mode sequencer with result FIFO, per-channel coefficient store and serial result shifter.
// Assumes command decode, filter data and gain/channel fields come from logic on sys_clk;
// sclk and cs_n come from the host pins.
//
// What this block does
// - Mode zero converts repeatedly, ready low
// - Continuous read shifts each result out automatically
// - Otherwise a read request presents stored result
// - First result after two periods, then one
// - Single: settle 1 ms, two periods, power down
// - Single result and ready held until read
// - Idle holds filter in reset, clocks running
// - Power-down disables all circuitry and clock output
// - Internal zero-scale shorts inputs, two cycles
// - Calibration raises ready, lowers at end, idles
// - Zero-scale result written to channel offset
// - Internal full-scale: two cycles unity, else four
// - Full-scale result written to channel full-scale
// - System zero-scale finishes in two cycles
// - System full-scale finishes in two cycles
// - Mode field is bits 15 to 13
`timescale 1ns/1ns
`include "adc_seq_map.svh"

// ==========================================================================
// Synchronous FIFO
module seq_fifo #(
	parameter int W = 24,
	parameter int D = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic push;
	logic pop;

	// Extra pointer bit tells full from empty
	assign in_ready = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
	assign out_valid = wr_q != rd_q;
	assign out_data = mem[rd_q[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Storage is not reset; only the pointers carry meaning
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q[AW-1:0]] <= in_data;
		end
	end

	// Pointers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end
endmodule

// ==========================================================================
// Sequencer top
module adc_operating_mode_sequencer #(
	parameter int unsigned ODR_CYC = int'((64'(`SYS_CLK_MHZ) * 64'd1000000000) / 64'(`F_ADC_MILLIHZ)),
	parameter int unsigned SETTLE_CYC = `SYS_CLK_MHZ * `OSC_SETTLE_US
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic mode_wr,
	input wire logic [15:0] mode_word,
	input wire logic cfg_wr,
	input wire logic io_wr,
	input wire logic [2:0] channel_select,
	input wire logic [2:0] gain_code,
	input wire logic cont_read,
	input wire logic read_req,
	input wire logic [`RES_W-1:0] filter_data,
	input wire logic clock_output_driver_req,
	input wire logic [2:0] coef_rd_chan,
	input wire logic sclk,
	input wire logic cs_n,
	output logic dout,
	output logic rdy_n,
	output logic word_presented,
	output adc_seq_pkg::ctrl_t ctrl,
	output logic [`RES_W-1:0] offset_rd,
	output logic [`RES_W-1:0] fs_rd
);
	adc_seq_pkg::seq_state_t state_q;
	adc_seq_pkg::ctrl_t ctrl_q;
	logic [2:0] mode_q;
	logic [2:0] new_mode;
	logic [2:0] chan_q;
	logic [2:0] per_left_q;
	logic [2:0] cal_len;
	logic [31:0] cnt_q;
	logic [31:0] lim;
	logic restart;
	logic timed;
	logic tick;
	logic stall;
	logic fire;
	logic cal_start;
	logic [`RES_W-1:0] data_q;
	logic [`RES_W-1:0] tx_word_q;
	logic tx_valid_q;
	logic read_pend_q;
	logic rdy_n_q;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [`RES_W-1:0] fifo_out_data;
	logic [`RES_W-1:0] offset_mem [`CHAN_COUNT];
	logic [`RES_W-1:0] fs_mem [`CHAN_COUNT];
	logic [`RES_W-1:0] offset_rd_q;
	logic [`RES_W-1:0] fs_rd_q;
	logic done_tgl_q;
	logic done_s1_q;
	logic done_s2_q;
	logic done_s3_q;
	logic done_pulse;
	logic [4:0] bit_cnt_q;
	logic dout_q;

	// ==========================================================================
	// Restart decode
	// Field and other writes take effect in the same cycle as the strobe
	assign new_mode = mode_wr ? mode_word[`MODE_MSB:`MODE_LSB] : mode_q;
	// Config, IO and channel writes only retime free-running conversion; a
	// finished calibration or single shot must not be rerun by them
	assign restart = mode_wr || ((cfg_wr || io_wr || (channel_select != chan_q)) && state_q == adc_seq_pkg::ST_CONV);
	assign cal_start = restart && new_mode[2];
	// Internal full-scale needs longer above unity gain
	assign cal_len = (new_mode == `OPM_INT_FS && gain_code != `GAIN_UNITY) ? `CAL_LONG : `CAL_SHORT;

	// Mode field storage
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			mode_q <= `OPM_CONT;
		end else if (mode_wr) begin
			mode_q <= mode_word[`MODE_MSB:`MODE_LSB];
		end
	end

	// Channel tracker for change detection
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			chan_q <= 3'h0;
		end else begin
			chan_q <= channel_select;
		end
	end

	// ==========================================================================
	// Period timer
	assign timed = state_q == adc_seq_pkg::ST_CONV || state_q == adc_seq_pkg::ST_SETTLE ||
		state_q == adc_seq_pkg::ST_SINGLE || state_q == adc_seq_pkg::ST_CAL;
	assign lim = (state_q == adc_seq_pkg::ST_SETTLE) ? SETTLE_CYC : ODR_CYC;
	assign tick = timed && (cnt_q == lim - 32'h1);
	// A full FIFO holds the result back rather than losing it
	assign stall = cont_read && !fifo_in_ready && per_left_q == `LAST_PERIOD &&
		(state_q == adc_seq_pkg::ST_CONV || state_q == adc_seq_pkg::ST_SINGLE);
	assign fire = tick && !stall && per_left_q == `LAST_PERIOD && state_q != adc_seq_pkg::ST_SETTLE;

	// Sequencer state, period count and cycle count
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= adc_seq_pkg::ST_CONV;
			per_left_q <= `CONV_FIRST;
			cnt_q <= 32'h0;
		end else if (restart) begin
			cnt_q <= 32'h0;
			case (new_mode)
				`OPM_CONT: begin
					state_q <= adc_seq_pkg::ST_CONV;
					per_left_q <= `CONV_FIRST;
				end
				`OPM_SINGLE: begin
					state_q <= adc_seq_pkg::ST_SETTLE;
					per_left_q <= `CONV_FIRST;
				end
				`OPM_IDLE: begin
					state_q <= adc_seq_pkg::ST_IDLE;
				end
				`OPM_PWRDN: begin
					state_q <= adc_seq_pkg::ST_PWRDN;
				end
				default: begin
					state_q <= adc_seq_pkg::ST_CAL;
					per_left_q <= cal_len;
				end
			endcase
		end else if (timed) begin
			if (!tick) begin
				cnt_q <= cnt_q + 32'h1;
			end else if (!stall) begin
				cnt_q <= 32'h0;
				case (state_q)
					adc_seq_pkg::ST_SETTLE: begin
						state_q <= adc_seq_pkg::ST_SINGLE;
						per_left_q <= `CONV_FIRST;
					end
					default: begin
						if (per_left_q != `LAST_PERIOD) begin
							per_left_q <= per_left_q - 3'h1;
						end else if (state_q == adc_seq_pkg::ST_SINGLE) begin
							state_q <= adc_seq_pkg::ST_PWRDN;
						end else if (state_q == adc_seq_pkg::ST_CAL) begin
							state_q <= adc_seq_pkg::ST_IDLE;
						end
					end
				endcase
			end
		end
	end

	// ==========================================================================
	// Front-end controls, one cycle behind the state
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= '0;
		end else begin
			ctrl_q.filter_rst <= state_q == adc_seq_pkg::ST_IDLE || state_q == adc_seq_pkg::ST_PWRDN ||
				state_q == adc_seq_pkg::ST_SETTLE;
			ctrl_q.mod_clk_en <= state_q != adc_seq_pkg::ST_PWRDN && state_q != adc_seq_pkg::ST_SETTLE;
			ctrl_q.analog_pd <= state_q == adc_seq_pkg::ST_PWRDN;
			ctrl_q.input_short <= state_q == adc_seq_pkg::ST_CAL && mode_q == `OPM_INT_ZS;
			ctrl_q.fs_ref_apply <= state_q == adc_seq_pkg::ST_CAL && mode_q == `OPM_INT_FS;
			ctrl_q.clock_output_driver_en <= clock_output_driver_req && state_q != adc_seq_pkg::ST_PWRDN;
		end
	end

	// ==========================================================================
	// Results and ready flag
	// Data register takes each finished conversion
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			data_q <= '0;
		end else if (fire && state_q != adc_seq_pkg::ST_CAL) begin
			data_q <= filter_data;
		end
	end

	// Ready: completion wins over a read finishing in the same cycle
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rdy_n_q <= 1'b1;
		end else if (fire) begin
			rdy_n_q <= 1'b0;
		end else if (cal_start) begin
			rdy_n_q <= 1'b1;
		end else if (done_pulse && tx_valid_q) begin
			rdy_n_q <= 1'b1;
		end
	end

	// Coefficient store, written at the end of a calibration
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < `CHAN_COUNT; i++) begin
				offset_mem[i] <= '0;
				fs_mem[i] <= '0;
			end
		end else if (fire && state_q == adc_seq_pkg::ST_CAL) begin
			if (!mode_q[0]) begin
				offset_mem[chan_q] <= filter_data;
			end else begin
				fs_mem[chan_q] <= filter_data;
			end
		end
	end

	// Coefficient readback
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			offset_rd_q <= '0;
			fs_rd_q <= '0;
		end else begin
			offset_rd_q <= offset_mem[coef_rd_chan];
			fs_rd_q <= fs_mem[coef_rd_chan];
		end
	end

	// ==========================================================================
	// Result FIFO toward the serial side
	assign fifo_in_valid = fire && cont_read && state_q != adc_seq_pkg::ST_CAL;
	assign fifo_out_ready = cont_read && !tx_valid_q;

	seq_fifo #(
		.W(`RES_W),
		.D(`FIFO_DEPTH)
	) u_fifo (
		.clk(sys_clk),
		.rstn(rstn),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(filter_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// Pending read request until the slot is free
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			read_pend_q <= 1'b0;
		end else if (read_req) begin
			read_pend_q <= 1'b1;
		end else if (!tx_valid_q && !cont_read) begin
			read_pend_q <= 1'b0;
		end
	end

	// Presented word; held still while the link shifts it
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tx_valid_q <= 1'b0;
			tx_word_q <= '0;
		end else if (tx_valid_q) begin
			if (done_pulse) begin
				tx_valid_q <= 1'b0;
			end
		end else if (cont_read && fifo_out_valid) begin
			tx_valid_q <= 1'b1;
			tx_word_q <= fifo_out_data;
		end else if (!cont_read && read_pend_q) begin
			tx_valid_q <= 1'b1;
			tx_word_q <= data_q;
		end
	end

	// Frame-done toggle brought over from the serial clock
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			done_s1_q <= 1'b0;
			done_s2_q <= 1'b0;
			done_s3_q <= 1'b0;
		end else begin
			done_s1_q <= done_tgl_q;
			done_s2_q <= done_s1_q;
			done_s3_q <= done_s2_q;
		end
	end
	assign done_pulse = done_s2_q ^ done_s3_q;

	// ==========================================================================
	// Serial side on sclk
	// The word is quasi-static here: it changes only after this side reports a
	// finished frame, so it may be read without a synchroniser
	always_ff @(posedge sclk or negedge rstn or posedge cs_n) begin
		if (!rstn) begin
			bit_cnt_q <= 5'h0;
			dout_q <= 1'b0;
		end else if (cs_n) begin
			bit_cnt_q <= 5'h0;
			dout_q <= 1'b0;
		end else if (bit_cnt_q != `FRAME_BITS) begin
			dout_q <= tx_word_q[5'(`FRAME_BITS - 5'h1 - bit_cnt_q)];
			bit_cnt_q <= bit_cnt_q + 5'h1;
		end
	end

	// Frame completion toggle, reset only by the system reset
	always_ff @(posedge sclk or negedge rstn) begin
		if (!rstn) begin
			done_tgl_q <= 1'b0;
		end else if (!cs_n && bit_cnt_q == `FRAME_BITS - 5'h1) begin
			done_tgl_q <= ~done_tgl_q;
		end
	end

	assign dout = dout_q;
	assign rdy_n = rdy_n_q;
	assign word_presented = tx_valid_q;
	assign ctrl = ctrl_q;
	assign offset_rd = offset_rd_q;
	assign fs_rd = fs_rd_q;

	// ==========================================================================
	// Assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	property p_conv_ready;
		fire && state_q == adc_seq_pkg::ST_CONV |=> !rdy_n_q && data_q == $past(filter_data);
	endproperty
	a_conv_ready: assert property (p_conv_ready) else $error("conversion did not store or drop ready");

	property p_cont_push;
		fire && cont_read && state_q == adc_seq_pkg::ST_CONV |-> fifo_in_valid && fifo_in_ready;
	endproperty
	a_cont_push: assert property (p_cont_push) else $error("result not queued in continuous read");

	property p_read_load;
		!tx_valid_q && !cont_read && read_pend_q && !restart |=> tx_valid_q && tx_word_q == $past(data_q);
	endproperty
	a_read_load: assert property (p_read_load) else $error("read request did not present result");

	property p_first_two;
		mode_wr && mode_word[`MODE_MSB:`MODE_LSB] == `OPM_CONT |=>
			state_q == adc_seq_pkg::ST_CONV && per_left_q == `CONV_FIRST && cnt_q == 32'h0;
	endproperty
	a_first_two: assert property (p_first_two) else $error("continuous start not two periods");

	property p_single_flow;
		state_q == adc_seq_pkg::ST_SETTLE && tick && !restart |=>
			state_q == adc_seq_pkg::ST_SINGLE && per_left_q == `CONV_FIRST;
	endproperty
	a_single_flow: assert property (p_single_flow) else $error("settle did not lead to conversion");

	property p_single_hold;
		state_q == adc_seq_pkg::ST_PWRDN && !rdy_n_q && !done_pulse && !mode_wr |=> !rdy_n_q;
	endproperty
	a_single_hold: assert property (p_single_hold) else $error("single result ready lost");

	property p_idle_ctrl;
		state_q == adc_seq_pkg::ST_IDLE ##1 state_q == adc_seq_pkg::ST_IDLE |-> ctrl_q.filter_rst && ctrl_q.mod_clk_en;
	endproperty
	a_idle_ctrl: assert property (p_idle_ctrl) else $error("idle controls wrong");

	property p_pd_ctrl;
		state_q == adc_seq_pkg::ST_PWRDN |=> ctrl_q.analog_pd && !ctrl_q.clock_output_driver_en && !ctrl_q.mod_clk_en;
	endproperty
	a_pd_ctrl: assert property (p_pd_ctrl) else $error("power-down left circuitry on");

	property p_short;
		state_q == adc_seq_pkg::ST_CAL && mode_q == `OPM_INT_ZS |=> ctrl_q.input_short;
	endproperty
	a_short: assert property (p_short) else $error("inputs not shorted in zero-scale");

	property p_cal_ready;
		cal_start |=> rdy_n_q && state_q == adc_seq_pkg::ST_CAL;
	endproperty
	a_cal_ready: assert property (p_cal_ready) else $error("calibration start did not raise ready");

	property p_cal_end;
		fire && state_q == adc_seq_pkg::ST_CAL && !restart |=> state_q == adc_seq_pkg::ST_IDLE && !rdy_n_q;
	endproperty
	a_cal_end: assert property (p_cal_end) else $error("calibration end not idle with ready");

	property p_offset_wr;
		fire && state_q == adc_seq_pkg::ST_CAL && !mode_q[0] |=> offset_mem[$past(chan_q)] == $past(filter_data);
	endproperty
	a_offset_wr: assert property (p_offset_wr) else $error("offset coefficient not written");

	property p_fs_wr;
		fire && state_q == adc_seq_pkg::ST_CAL && mode_q[0] |=> fs_mem[$past(chan_q)] == $past(filter_data);
	endproperty
	a_fs_wr: assert property (p_fs_wr) else $error("full-scale coefficient not written");

	property p_fs_len;
		mode_wr && mode_word[`MODE_MSB:`MODE_LSB] == `OPM_INT_FS && gain_code != `GAIN_UNITY |=> per_left_q == `CAL_LONG;
	endproperty
	a_fs_len: assert property (p_fs_len) else $error("internal full-scale length wrong");

	property p_sys_len;
		mode_wr && mode_word[`MODE_MSB:`MODE_MSB - 1] == 2'h3 |=> per_left_q == `CAL_SHORT;
	endproperty
	a_sys_len: assert property (p_sys_len) else $error("system calibration length wrong");

	property p_mode_field;
		mode_wr |=> mode_q == $past(mode_word[`MODE_MSB:`MODE_LSB]) && cnt_q == 32'h0;
	endproperty
	a_mode_field: assert property (p_mode_field) else $error("mode write not taken or not restarted");

	c_cont: cover property (fire && cont_read && state_q == adc_seq_pkg::ST_CONV);
	c_single: cover property (state_q == adc_seq_pkg::ST_SINGLE ##1 state_q == adc_seq_pkg::ST_PWRDN);
	c_cal: cover property (fire && state_q == adc_seq_pkg::ST_CAL);
	c_read: cover property (done_pulse && tx_valid_q);
endmodule

// ===== adc_operating_mode_sequencer_test.sv
// Self-checking bench for the operating-mode sequencer.
// Assumes shortened period counts; the host model reads results over the serial pins.
`timescale 1ns/1ns

module adc_operating_mode_sequencer_test;
	localparam int ODR = 200;
	localparam int STL = 20;
	logic sys_clk, rstn, mode_wr, cfg_wr, io_wr, cont_read, read_req, clock_output_driver_req;
	logic [15:0] mode_word;
	logic [2:0] channel_select, gain_code, coef_rd_chan;
	logic [23:0] filter_data, w, offset_rd, fs_rd;
	logic sclk, cs_n, dout, rdy_n, word_presented;
	adc_seq_pkg::ctrl_t ctrl;
	int err_total = 0;
	int num_checks = 0;
	int cyc = 0;
	int t0, n;

	// ==========================================================================
	// Instances
	adc_operating_mode_sequencer #(.ODR_CYC(ODR), .SETTLE_CYC(STL)) dut (.sys_clk, .rstn, .mode_wr, .mode_word,
		.cfg_wr, .io_wr, .channel_select, .gain_code, .cont_read, .read_req, .filter_data, .clock_output_driver_req,
		.coef_rd_chan, .sclk, .cs_n, .dout, .rdy_n, .word_presented, .ctrl, .offset_rd, .fs_rd);
	adc_host_model host (.sclk, .cs_n, .dout);

	// Clock and a cycle count for period measurements
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) cyc <= cyc + 1;

	// ==========================================================================
	// Shared tasks
	task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string msg);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t %s: seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(negedge sys_clk);
	endtask

	// Junk in the unused low bits proves only the top three are decoded
	task automatic mode(input logic [2:0] code);
		mode_word = {code, 13'h1fff};
		mode_wr = 1'b1;
		tick(1);
		mode_wr = 1'b0;
	endtask

	// Ready must stay high up to lo cycles and fall by hi
	task automatic wait_rdy(input int lo, input int hi);
		int i;
		tick(lo);
		check(rdy_n, 1'b1, "ready early");
		for (i = lo; i < hi && rdy_n !== 1'b0; i++) tick(1);
		check(rdy_n, 1'b0, "ready late");
	endtask

	// Read request when needed, then one whole frame
	task automatic read_word();
		int i;
		// Line up on a falling edge whatever the caller left behind
		tick(1);
		if (!cont_read) begin
			read_req = 1'b1;
			tick(1);
			read_req = 1'b0;
		end
		for (i = 0; i < 10 && word_presented !== 1'b1; i++) tick(1);
		check(word_presented, 1'b1, "no word");
		host.frame(24, w);
		tick(1);
		for (i = 0; i < 10 && word_presented !== 1'b0; i++) tick(1);
		check(word_presented, 1'b0, "word kept");
	endtask

	// ==========================================================================
	// Scenarios
	task automatic t_restart();
		for (int k = 0; k < 4; k++) begin
			mode(3'h0);
			filter_data = 24'h5a0f00 + 24'(k);
			read_word();
			// Restart mid-conversion so an unrestarted timer would fire early
			case (k)
				1: cfg_wr = 1'b1;
				2: io_wr = 1'b1;
				3: channel_select = 3'h4;
				default: mode_wr = 1'b1;
			endcase
			tick(1);
			{mode_wr, cfg_wr, io_wr} = 3'h0;
			wait_rdy(2 * ODR - 3, 2 * ODR + 4);
			t0 = cyc;
			// Short frame plus a read must finish well inside one period
			if (k == 0) host.frame(4, w);
			read_word();
			check(w, filter_data, "result");
			check(rdy_n, 1'b1, "ready after read");
			while (rdy_n !== 1'b0 && cyc - t0 < 2 * ODR) tick(1);
			check(24'(cyc - t0), 24'(ODR), "period");
		end
	endtask

	task automatic t_single();
		mode(3'h2);
		tick(2);
		check(ctrl[5:3], 3'h6, "idle ctrl");
		read_word();
		clock_output_driver_req = 1'b1;
		filter_data = 24'hc3a5e1;
		mode(3'h1);
		tick(2);
		check(ctrl.mod_clk_en, 1'b0, "settle clock");
		wait_rdy(STL + 2 * ODR - 4, STL + 2 * ODR + 6);
		tick(100);
		check(rdy_n, 1'b0, "ready held");
		check({ctrl.analog_pd, ctrl.clock_output_driver_en}, 2'h2, "power-down");
		read_word();
		check(w, filter_data, "single result");
		check(rdy_n, 1'b1, "ready after read");
		clock_output_driver_req = 1'b0;
	endtask

	task automatic t_cal(input logic [2:0] code, input logic [2:0] ch, input logic [2:0] g, input int np,
			input logic [23:0] val);
		channel_select = ch;
		gain_code = g;
		filter_data = val;
		tick(2);
		mode(code);
		tick(2);
		check(rdy_n, 1'b1, "cal ready high");
		check(ctrl.input_short, code == 3'h4, "short");
		check(ctrl.fs_ref_apply, code == 3'h5, "fs apply");
		wait_rdy(np * ODR - 3, np * ODR + 4);
		tick(3);
		check(ctrl[5:3], 3'h6, "idle after cal");
		coef_rd_chan = ch;
		tick(2);
		check(code[0] ? fs_rd : offset_rd, val, "coefficient");
	endtask

	// Fill the buffer until conversions stall, then drain it with a stopped converter
	task automatic t_fifo();
		cont_read = 1'b1;
		filter_data = 24'h3c5a96;
		mode(3'h0);
		tick(12 * ODR);
		check(word_presented, 1'b1, "no word");
		mode(3'h2);
		n = 0;
		while (word_presented === 1'b1 && n < 12) begin
			host.frame(24, w);
			check(w, filter_data, "stream word");
			n++;
			tick(8);
		end
		check(24'(n), 24'h9, "buffer depth");
		cont_read = 1'b0;
	endtask

	// ==========================================================================
	// Verdict and main sequence
	task automatic print_verdict();
		$display("Checks run %0d, errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// A hang costs far more than the roughly 90 us the scenarios need
	initial begin
		#400000;
		err_total++;
		print_verdict();
	end

	initial begin
		{rstn, mode_wr, cfg_wr, io_wr, cont_read, read_req, clock_output_driver_req} = 7'h0;
		{mode_word, channel_select, gain_code, coef_rd_chan, filter_data} = 49'h0;
		tick(6);
		check({rdy_n, word_presented, ctrl}, 8'h80, "reset outputs");
		rstn = 1'b1;
		tick(2);
		check(ctrl, 6'h10, "continuous ctrl");
		wait_rdy(2 * ODR - 5, 2 * ODR + 5);
		t_restart();
		t_single();
		t_cal(3'h4, 3'h1, 3'h0, 2, 24'h012345);
		t_cal(3'h5, 3'h2, 3'h0, 2, 24'h6789ab);
		t_cal(3'h5, 3'h2, 3'h3, 4, 24'hcdef01);
		t_cal(3'h6, 3'h5, 3'h0, 2, 24'h2468ac);
		t_cal(3'h7, 3'h7, 3'h7, 2, 24'h13579b);
		t_fifo();
		print_verdict();
	end
endmodule

// ===== adc_seq_map.svh
// Named constants for the operating-mode sequencer: mode field, mode codes, widths, timing figures.
// Assumes a 125 MHz system clock; included by bare name wherever the numbers are needed.
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

// ==========================================================================
// Mode word layout
`define MODE_MSB 15
`define MODE_LSB 13

// ==========================================================================
// Operating mode codes
`define OPM_CONT 3'h0
`define OPM_SINGLE 3'h1
`define OPM_IDLE 3'h2
`define OPM_PWRDN 3'h3
`define OPM_INT_ZS 3'h4
`define OPM_INT_FS 3'h5
`define OPM_SYS_ZS 3'h6
`define OPM_SYS_FS 3'h7

// ==========================================================================
// Gain codes
`define GAIN_UNITY 3'h0
`define GAIN_128 3'h7

// ==========================================================================
// Data path
`define RES_W 24
`define FIFO_DEPTH 8
`define CHAN_COUNT 8
`define FRAME_BITS 5'h18

// ==========================================================================
// Timing
`define SYS_CLK_MHZ 125
`define OSC_SETTLE_US 1000
`define F_ADC_MILLIHZ 16700
`define CONV_FIRST 3'h2
`define CAL_SHORT 3'h2
`define CAL_LONG 3'h4
`define LAST_PERIOD 3'h1

`endif

// ===== adc_seq_pkg.sv
// Types shared by the operating-mode sequencer.
// Assumes adc_seq_map.svh supplies all numeric constants.
package adc_seq_pkg;

	// ==========================================================================
	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PWRDN,
		ST_CONV,
		ST_SETTLE,
		ST_SINGLE,
		ST_CAL
	} seq_state_t;

	// ==========================================================================
	// Controls toward the analog front end and clock pin
	typedef struct packed {
		logic filter_rst;
		logic mod_clk_en;
		logic analog_pd;
		logic input_short;
		logic fs_ref_apply;
		logic clock_output_driver_en;
	} ctrl_t;

endpackage
